// ==== wdt_pkg.sv ====
// Constants, register map and types of the two-stage watchdog.
// Assumes an APB slave with 32-bit data and one clock domain.
`default_nettype none
package wdt_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_LOAD1  = 8'h04;
   localparam logic [7:0] OFF_LOAD2  = 8'h08;
   localparam logic [7:0] OFF_CMD    = 8'h0c;
   localparam logic [7:0] OFF_CNT1   = 8'h10;
   localparam logic [7:0] OFF_CNT2   = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_MASK   = 8'h1c;
   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_SCI    = 1;
   localparam int CTRL_NMI    = 2;
   localparam int CTRL_SMI    = 3;
   localparam int CTRL_RESET  = 4;
   localparam int CTRL_FALL   = 5;
   localparam int CTRL_EARLY  = 6;
   localparam int CTRL_HWEN   = 7;
   localparam int CTRL_W      = 8;
   // Command register: bit 0 retrigger
   localparam int CMD_RETRIG  = 0;
   // ************************************************************
   // Status fields
   // ************************************************************
   localparam int ST_TIMEOUT1 = 0;
   localparam int ST_TIMEOUT2 = 1;
   localparam int ST_HWTRIG   = 2;
   localparam int ST_W        = 3;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h00;
   localparam logic [31:0]       LOAD1_RST = 32'h0000ffff;
   localparam logic [31:0]       LOAD2_RST = 32'h000000ff;
   localparam logic [ST_W-1:0]   MASK_RST  = 3'h0;
   // Length of reset pulse to the system, cycles
   localparam logic [7:0]        RESET_PULSE_CYC = 8'h10;

   typedef enum logic [1:0] {ST_IDLE, ST_STAGE1, ST_STAGE2, ST_RESET}
      wd_state_e;
endpackage
`default_nettype wire

// ==== edge_detect.sv ====
// Selectable edge detector for the retrigger input.
// Assumes the input is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
   // Clock and reset
   input  wire logic SYS_CLK,
   input  wire logic RST_N,
   // Signal
   input  wire logic sig_in,
   input  wire logic fall_sel,
   output logic      pulse
);
   typedef struct packed {
      logic prev;
   } ed_s;
   ed_s r;
   ed_s next_r;

   always_comb begin
      next_r      = r;
      next_r.prev = sig_in;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Combinational so a looped-back early output acts in time
   assign pulse = fall_sel ? (r.prev & ~sig_in)
                           : (~r.prev & sig_in);
endmodule
`default_nettype wire

// ==== down_counter.sv ====
// Loadable down counter with a zero flag.
// Assumes load wins over count.
`timescale 1ns/10ps
`default_nettype none
module down_counter #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         SYS_CLK,
   input  wire logic         RST_N,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         run,
   // State
   output logic [W-1:0]      count,
   output logic              is_zero,
   output logic              is_one
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } dc_s;
   dc_s r;
   dc_s next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.cnt = load_val;
      end else if (run && r.cnt != '0) begin
         next_r.cnt = r.cnt - W'(1);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign count   = r.cnt;
   assign is_zero = (r.cnt == '0);
   assign is_one  = (r.cnt == W'(1));
endmodule
`default_nettype wire

// ==== wdt_top.sv ====
// Two-stage watchdog with APB registers and interrupt status.
// Assumes APB master on SYS_CLK; retrigger input synchronous.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module wdt_top #(
   parameter int CW = 32
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Watchdog pins
   input  wire logic        RETRIGGER_IN,
   output logic             TIMEOUT_OUT,
   output logic             SCI_OUT,
   output logic             NMI_OUT,
   output logic             SMI_OUT,
   output logic             SYS_RESET_OUT,
   // Interrupt
   output logic             IRQ
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [wdt_pkg::CTRL_W-1:0] ctrl;
      logic [CW-1:0]              load1;
      logic [CW-1:0]              load2;
      logic [wdt_pkg::ST_W-1:0]   status;
      logic [wdt_pkg::ST_W-1:0]   mask;
      wdt_pkg::wd_state_e         state;
      logic [7:0]                 rst_cnt;
      logic                       tout;
      logic                       sci;
      logic                       nmi;
      logic                       smi;
      logic                       sysrst;
      logic [31:0]                rdata;
   } wdt_s;
   wdt_s r;
   wdt_s next_r;

   logic          hw_edge;
   logic [CW-1:0] cnt1;
   logic [CW-1:0] cnt2;
   logic          zero1;
   logic          one1;
   logic          zero2;
   logic          one2_unused;
   logic          load1_now;
   logic          load2_now;
   logic          run1;
   logic          run2;
   logic          retrig;
   logic          sw_retrig;
   logic          hw_retrig;
   logic          fire1;
   logic          fire2;
   logic          wr;
   logic          rd;
   logic          mapped;

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         wdt_pkg::OFF_CTRL, wdt_pkg::OFF_LOAD1, wdt_pkg::OFF_LOAD2,
         wdt_pkg::OFF_CMD, wdt_pkg::OFF_CNT1, wdt_pkg::OFF_CNT2,
         wdt_pkg::OFF_STATUS, wdt_pkg::OFF_MASK: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // ************************************************************
   // Submodules
   // ************************************************************
   edge_detect u_edge (
      .SYS_CLK  (SYS_CLK),
      .RST_N    (RST_N),
      .sig_in   (RETRIGGER_IN),
      .fall_sel (r.ctrl[wdt_pkg::CTRL_FALL]),
      .pulse    (hw_edge)
   );

   down_counter #(.W(CW)) u_first_stage_counter (
      .SYS_CLK  (SYS_CLK),
      .RST_N    (RST_N),
      .load     (load1_now),
      .load_val (r.load1),
      .run      (run1),
      .count    (cnt1),
      .is_zero  (zero1),
      .is_one   (one1)
   );

   down_counter #(.W(CW)) u_reset_delay_counter (
      .SYS_CLK  (SYS_CLK),
      .RST_N    (RST_N),
      .load     (load2_now),
      .load_val (r.load2),
      .run      (run2),
      .count    (cnt2),
      .is_zero  (zero2),
      .is_one   (one2_unused)
   );

   // ************************************************************
   // Bus decode and counter control
   // ************************************************************
   assign mapped    = is_mapped(PADDR);
   assign wr        = PSEL & PENABLE & PWRITE & mapped;
   assign rd        = PSEL & PENABLE & ~PWRITE;
   assign sw_retrig = wr && PADDR == wdt_pkg::OFF_CMD
                      && PWDATA[wdt_pkg::CMD_RETRIG];
   assign hw_retrig = hw_edge & r.ctrl[wdt_pkg::CTRL_HWEN];
   // Software path always open, hardware only when enabled
   assign retrig    = sw_retrig | hw_retrig;
   // Retrigger only counts while stage one runs
   assign load1_now = (r.state == wdt_pkg::ST_IDLE)
                      || (r.state == wdt_pkg::ST_STAGE1 && retrig);
   assign run1      = (r.state == wdt_pkg::ST_STAGE1);
   assign fire1     = run1 && zero1 && !retrig;
   // Second counter always reloads from a software value
   assign load2_now = (r.state != wdt_pkg::ST_STAGE2);
   assign run2      = (r.state == wdt_pkg::ST_STAGE2);
   assign fire2     = run2 && zero2;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_r        = r;
      next_r.tout   = 1'b0;
      next_r.sci    = 1'b0;
      next_r.nmi    = 1'b0;
      next_r.smi    = 1'b0;
      next_r.sysrst = 1'b0;

      // Register writes
      if (wr) begin
         case (PADDR)
            wdt_pkg::OFF_CTRL:  next_r.ctrl  = PWDATA[wdt_pkg::CTRL_W-1:0];
            wdt_pkg::OFF_LOAD1: next_r.load1 = PWDATA[CW-1:0];
            wdt_pkg::OFF_LOAD2: next_r.load2 = PWDATA[CW-1:0];
            wdt_pkg::OFF_MASK:  next_r.mask  = PWDATA[wdt_pkg::ST_W-1:0];
            wdt_pkg::OFF_STATUS: begin
               next_r.status = r.status & ~PWDATA[wdt_pkg::ST_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data registered in the setup cycle
      if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            wdt_pkg::OFF_CTRL:   next_r.rdata = 32'(r.ctrl);
            wdt_pkg::OFF_LOAD1:  next_r.rdata = 32'(r.load1);
            wdt_pkg::OFF_LOAD2:  next_r.rdata = 32'(r.load2);
            wdt_pkg::OFF_CNT1:   next_r.rdata = 32'(cnt1);
            wdt_pkg::OFF_CNT2:   next_r.rdata = 32'(cnt2);
            wdt_pkg::OFF_STATUS: next_r.rdata = 32'(r.status);
            wdt_pkg::OFF_MASK:   next_r.rdata = 32'(r.mask);
            default:             next_r.rdata = 32'h00000000;
         endcase
      end

      // Early output: rises as the first counter hits zero, one cycle before the normal output
      if (run1 && !retrig) begin
         if (r.ctrl[wdt_pkg::CTRL_EARLY]) begin
            next_r.tout = one1;
         end else begin
            next_r.tout = zero1;
         end
      end

      case (r.state)
         wdt_pkg::ST_IDLE: begin
            if (r.ctrl[wdt_pkg::CTRL_ENABLE]) begin
               next_r.state = wdt_pkg::ST_STAGE1;
            end
         end
         wdt_pkg::ST_STAGE1: begin
            if (!r.ctrl[wdt_pkg::CTRL_ENABLE]) begin
               next_r.state = wdt_pkg::ST_IDLE;
            end else if (fire1) begin
               next_r.sci = r.ctrl[wdt_pkg::CTRL_SCI];
               next_r.nmi = r.ctrl[wdt_pkg::CTRL_NMI];
               next_r.smi = r.ctrl[wdt_pkg::CTRL_SMI];
               if (r.ctrl[wdt_pkg::CTRL_RESET]) begin
                  next_r.state   = wdt_pkg::ST_RESET;
                  next_r.rst_cnt = wdt_pkg::RESET_PULSE_CYC;
                  next_r.sysrst  = 1'b1;
               end else begin
                  next_r.state = wdt_pkg::ST_STAGE2;
               end
            end
         end
         wdt_pkg::ST_STAGE2: begin
            if (!r.ctrl[wdt_pkg::CTRL_ENABLE]) begin
               next_r.state = wdt_pkg::ST_IDLE;
            end else if (fire2) begin
               next_r.state   = wdt_pkg::ST_RESET;
               next_r.rst_cnt = wdt_pkg::RESET_PULSE_CYC;
               next_r.sysrst  = 1'b1;
            end
         end
         wdt_pkg::ST_RESET: begin
            // Reset pulse holds a fixed length, then restarts
            if (r.rst_cnt > 8'h01) begin
               next_r.sysrst  = 1'b1;
               next_r.rst_cnt = r.rst_cnt - 8'h01;
            end else begin
               next_r.state = wdt_pkg::ST_IDLE;
            end
         end
         default: next_r.state = wdt_pkg::ST_IDLE;
      endcase

      // Sticky events; set wins over a same-cycle clear
      if (fire1) begin
         next_r.status[wdt_pkg::ST_TIMEOUT1] = 1'b1;
      end
      if (fire2) begin
         next_r.status[wdt_pkg::ST_TIMEOUT2] = 1'b1;
      end
      if (hw_retrig && r.state == wdt_pkg::ST_STAGE1) begin
         next_r.status[wdt_pkg::ST_HWTRIG] = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         r         <= '0;
         r.ctrl    <= wdt_pkg::CTRL_RST;
         r.load1   <= wdt_pkg::LOAD1_RST[CW-1:0];
         r.load2   <= wdt_pkg::LOAD2_RST[CW-1:0];
         r.mask    <= wdt_pkg::MASK_RST;
         r.state   <= wdt_pkg::ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign PRDATA        = r.rdata;
   assign PREADY        = 1'b1;
   assign PSLVERR       = PSEL & PENABLE & ~mapped;
   assign TIMEOUT_OUT   = r.tout;
   assign SCI_OUT       = r.sci;
   assign NMI_OUT       = r.nmi;
   assign SMI_OUT       = r.smi;
   assign SYS_RESET_OUT = r.sysrst;
   assign IRQ           = |(r.status & r.mask);
endmodule
`default_nettype wire

// ==== wdt_sva.sv ====
// Checker for the watchdog top: event pulses and reset timing.
// Assumes a bind to wdt_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module wdt_sva (
   // Clock and reset
   input wire logic       SYS_CLK,
   input wire logic       RST_N,
   // APB
   input wire logic       PSEL,
   input wire logic       PENABLE,
   input wire logic       PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic       PREADY,
   input wire logic       PSLVERR,
   // Pins
   input wire logic       TIMEOUT_OUT,
   input wire logic       SCI_OUT,
   input wire logic       NMI_OUT,
   input wire logic       SMI_OUT,
   input wire logic       SYS_RESET_OUT
);
   logic [7:0] c;
   logic       to_d;
   logic       t1;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         c    <= 8'h00;
         to_d <= 1'b0;
      end else begin
         to_d <= TIMEOUT_OUT;
         if (PSEL && PENABLE && PWRITE && PREADY &&
             PADDR == wdt_pkg::OFF_CTRL)
            c <= PWDATA[7:0];
      end
   end
   // Early output leads the real timeout by one cycle
   assign t1 = c[wdt_pkg::CTRL_EARLY] ? to_d : TIMEOUT_OUT;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   property p_sci; SCI_OUT == (t1 && c[wdt_pkg::CTRL_SCI]); endproperty
   a_sci: assert property (p_sci) else $error("sci wrong");
   property p_nmi; NMI_OUT == (t1 && c[wdt_pkg::CTRL_NMI]); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi wrong");
   property p_smi; SMI_OUT == (t1 && c[wdt_pkg::CTRL_SMI]); endproperty
   a_smi: assert property (p_smi) else $error("smi wrong");
   property p_imm; t1 && c[wdt_pkg::CTRL_RESET] |-> SYS_RESET_OUT;
   endproperty
   a_imm: assert property (p_imm) else $error("no reset");
   property p_delay; t1 && !c[wdt_pkg::CTRL_RESET] |-> !SYS_RESET_OUT;
   endproperty
   a_delay: assert property (p_delay) else $error("early reset");
   property p_pulse; TIMEOUT_OUT |=> !TIMEOUT_OUT; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_rlen; $rose(SYS_RESET_OUT) |-> SYS_RESET_OUT[*8]; endproperty
   a_rlen: assert property (p_rlen) else $error("short reset");
   property p_err; PSEL && PENABLE && PADDR[7:5] != 3'h0 |-> PSLVERR;
   endproperty
   a_err: assert property (p_err) else $error("no slverr");
   cover property (SCI_OUT);
   cover property ($rose(SYS_RESET_OUT) && c[wdt_pkg::CTRL_RESET]);
   cover property (TIMEOUT_OUT && c[wdt_pkg::CTRL_EARLY]);
endmodule
bind wdt_top wdt_sva u_sva (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .TIMEOUT_OUT(TIMEOUT_OUT), .SCI_OUT(SCI_OUT), .NMI_OUT(NMI_OUT),
   .SMI_OUT(SMI_OUT), .SYS_RESET_OUT(SYS_RESET_OUT));
`default_nettype wire

// ==== wdt_partner.sv ====
// Host side: retrigger source and counts of watchdog events.
// Assumes pins synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module wdt_partner (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Bench control
   input  wire logic  loop,
   input  wire logic  lvl,
   input  wire logic  clr,
   // Device pins
   input  wire logic  timeout_out,
   input  wire logic  sci,
   input  wire logic  nmi,
   input  wire logic  smi,
   input  wire logic  sys_rst,
   output logic       retrigger_in,
   // Event counts
   output logic [4:0] n_sci,
   output logic [4:0] n_nmi,
   output logic [4:0] n_smi,
   output logic [4:0] n_rst
);
   // Wired loop-back or a held level from the bench
   assign retrigger_in = loop ? timeout_out : lvl;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n || clr) begin
         n_sci <= 5'h0;
         n_nmi <= 5'h0;
         n_smi <= 5'h0;
         n_rst <= 5'h0;
      end else begin
         n_sci <= n_sci + 5'(sci);
         n_nmi <= n_nmi + 5'(nmi);
         n_smi <= n_smi + 5'(smi);
         n_rst <= n_rst + 5'(sys_rst);
      end
   end
endmodule
`default_nettype wire

// ==== two_stage_watchdog_timer_tb_top.sv ====
// Bench for the watchdog: APB tasks and timed scenarios.
// Assumes wdt_top, wdt_partner and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module two_stage_watchdog_timer_tb_top;
   localparam logic [31:0] L1 = 32'h00000008;
   localparam logic [31:0] L2 = 32'h00000005;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        loop = 1'b0;
   logic        lvl = 1'b0;
   logic        clr = 1'b0;
   logic        m = 1'b0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, err, retrig, timeout_out, irq;
   logic        sci, nmi, smi, sys_reset_out;
   logic [4:0]  n_sci, n_nmi, n_smi, n_rst;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          k;
   always #2.5 sys_clk = ~sys_clk;
   wdt_top uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RETRIGGER_IN(retrig),
      .TIMEOUT_OUT(timeout_out), .SCI_OUT(sci), .NMI_OUT(nmi),
      .SMI_OUT(smi), .SYS_RESET_OUT(sys_reset_out), .IRQ(irq));
   wdt_partner u_host (.clk(sys_clk), .rst_n(rst_n), .loop(loop),
      .lvl(lvl), .clr(clr), .timeout_out(timeout_out), .sci(sci),
      .nmi(nmi), .smi(smi), .sys_rst(sys_reset_out),
      .retrigger_in(retrig), .n_sci(n_sci), .n_nmi(n_nmi),
      .n_smi(n_smi), .n_rst(n_rst));
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, rdat);
   endtask
   // Cycles until timeout (s=0) or system reset (s=1) is seen
   task automatic meas(input logic s, output int n);
      n = 0;
      while ((s ? sys_reset_out : timeout_out) !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask
   task automatic fin;
      meas(1'b1, k);
      while (sys_reset_out === 1'b1) begin
         @(posedge sys_clk);
         #1;
      end
      apb(1'b1, wdt_pkg::OFF_CTRL, 32'h0);
      apb(1'b1, wdt_pkg::OFF_STATUS, 32'h7);
   endtask
   task automatic run(input logic [7:0] c);
      logic [31:0] e;
      e = {31'h0, c[wdt_pkg::CTRL_EARLY]};
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      apb(1'b1, wdt_pkg::OFF_CTRL, {24'h0, c});
      meas(1'b0, k);
      chk("to_cyc", L1 + 2 - e, 32'(k));
      meas(1'b1, k);
      chk("rst_cyc", c[4] ? e : e + L2 + 1, 32'(k));
      rd(wdt_pkg::OFF_STATUS, c[4] ? 32'h1 : 32'h3);
      chk("irq", {31'h0, m}, {31'h0, irq});
      fin;
      chk("rst_len", 32'd16, {27'h0, n_rst});
      chk("sci", {31'h0, c[1]}, {27'h0, n_sci});
      chk("nmi", {31'h0, c[2]}, {27'h0, n_nmi});
      chk("smi", {31'h0, c[3]}, {27'h0, n_smi});
      rd(wdt_pkg::OFF_STATUS, 32'h0);
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask
   task automatic hw(input logic [7:0] c, input logic st,
                     input logic [31:0] e);
      @(posedge sys_clk);
      lvl <= st;
      apb(1'b1, wdt_pkg::OFF_CTRL, {24'h0, c});
      repeat (3) @(posedge sys_clk);
      lvl <= ~st;
      meas(1'b0, k);
      chk("hw_cyc", e, 32'(k));
      fin;
   endtask
   task automatic wrap_up;
      $display("compared %0d, bad %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(wdt_pkg::OFF_LOAD1, 32'h0000ffff);
      rd(wdt_pkg::OFF_LOAD2, 32'h000000ff);
      rd(wdt_pkg::OFF_CTRL, 32'h0);
      rd(wdt_pkg::OFF_MASK, 32'h0);
      rd(8'h20, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, wdt_pkg::OFF_LOAD1, L1);
      apb(1'b1, wdt_pkg::OFF_LOAD2, L2);
      rd(wdt_pkg::OFF_CNT1, L1);
      $display("register test done");
      run(8'h03);
      m = 1'b1;
      apb(1'b1, wdt_pkg::OFF_MASK, 32'h7);
      run(8'h15);
      run(8'h49);
      run(8'h5f);
      $display("flag test done");
      apb(1'b1, wdt_pkg::OFF_CTRL, 32'h1);
      repeat (4) apb(1'b1, wdt_pkg::OFF_CMD, 32'h1);
      meas(1'b0, k);
      chk("sw_cyc", L1 + 1, 32'(k));
      fin;
      hw(8'h81, 1'b0, L1 + 2);
      hw(8'ha1, 1'b1, L1 + 2);
      hw(8'h81, 1'b1, L1 - 1);
      hw(8'h01, 1'b0, L1 - 1);
      $display("retrigger test done");
      @(posedge sys_clk);
      lvl <= 1'b0;
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      loop <= 1'b1;
      apb(1'b1, wdt_pkg::OFF_CTRL, 32'hc1);
      repeat (40) @(posedge sys_clk);
      apb(1'b1, wdt_pkg::OFF_CTRL, 32'h0);
      loop <= 1'b0;
      chk("loop_rst", 32'h0, {27'h0, n_rst});
      rd(wdt_pkg::OFF_STATUS, 32'h4);
      $display("loop-back test done");
      wrap_up;
   end
endmodule
`default_nettype wire
